// ===== design/sfe_pkg.sv
// constants, types and register map of the spi transfer format engine
// How it works
// - every transfer shifts one byte out and one byte in together, timed by sck
// - as target, miso is driven only while the select input is low
// - idle polarity and sample phase bits pick one of four clock formats
// - phase 0: first edge captures the msb, select falling edge starts transfer
// - phase 0 target leaves idle on select fall and drives its msb at once
// - after a target start, writes wait in the buffer until the transfer ends
// - phase 1: the first sck edge starts the transfer
// - phase 1: select may stay low across consecutive transfers
// - phase 1 target leaves idle on first edge; later writes wait in buffer
// - as controller, a data write starts a transfer; phase leaves delay unchanged
// - controller phase 0 keeps sck idle first half; phase 1 opens with edge
// - controller bit clock free-runs from the bus clock only when enabled controller
// - controller sck edges are placed on the bus clock grid
// - start delay after a data write is at most one bit time
// - unread byte at overrun stays readable, new byte dropped, overrun flag set
// - role conflict flag rises when select level disagrees with the role
// - overrun is checked at the first capture strobe of the next transfer
// - transfer end sets receive full and stores byte; status then data read clears
// - controller: select low sets conflict; target: select high mid-transfer sets it
package sfe_pkg;
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0] SFE_ADDR_CTRL = 8'h10;
    localparam logic [7:0] SFE_ADDR_STAT = 8'h11;
    localparam logic [7:0] SFE_ADDR_DATA = 8'h12;
    localparam logic [7:0] SFE_CTRL_RESET = 8'h28;
    localparam int SFE_CTRL_MSTR = 5;
    localparam int SFE_CTRL_CLOCK_IDLE_POLARITY = 4;
    localparam int SFE_CTRL_CLOCK_SAMPLE_PHASE = 3;
    localparam int SFE_CTRL_EN = 1;
    localparam int SFE_STAT_FULL = 7;
    localparam int SFE_STAT_ERRIE = 6;
    localparam int SFE_STAT_OVR = 5;
    localparam int SFE_STAT_ROLE_CONFLICT_FLAG = 4;
    localparam int SFE_STAT_TXE = 3;
    localparam int SFE_STAT_MODFEN = 2;
    localparam int SFE_STAT_RATE_HI = 1;
    localparam int SFE_STAT_RATE_LO = 0;
    // ---------------------------------------------------------------
    // timing: half bit periods in bus cycles for each rate code
    // ---------------------------------------------------------------
    localparam logic [1:0] SFE_RATE_DIVIDE_BY_TWO = 2'h0;
    localparam logic [1:0] SFE_RATE_DIVIDE_BY_EIGHT = 2'h1;
    localparam logic [1:0] SFE_RATE_DIVIDE_BY_THIRTYTWO = 2'h2;
    localparam logic [6:0] SFE_HALF_DIVIDE_BY_TWO = 7'h01;
    localparam logic [6:0] SFE_HALF_DIVIDE_BY_EIGHT = 7'h04;
    localparam logic [6:0] SFE_HALF_DIVIDE_BY_THIRTYTWO = 7'h10;
    localparam logic [6:0] SFE_HALF_DIVIDE_BY_ONETWENTYEIGHT = 7'h40;
    localparam logic [4:0] SFE_EDGES = 5'h10;
    localparam logic [4:0] SFE_FIRST_EDGE = 5'h01;
    localparam logic [4:0] SFE_FIRST_SAMPLE_LIM = 5'h02;
    localparam logic [3:0] SFE_BITS = 4'h8;
    localparam logic [3:0] SFE_PIN_IDLE = 4'h1;
    // ---------------------------------------------------------------
    // carriers and states
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sfe_bus_req_type;
    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ss_n;
    } sfe_pin_in_type;
    typedef struct packed {
        logic sck_out;
        logic sck_oe;
        logic mosi_out;
        logic mosi_oe;
        logic miso_out;
        logic miso_oe;
    } sfe_pin_out_type;
    typedef enum {SFE_IDLE, SFE_WAIT, SFE_RUN} sfe_state_type;
endpackage

// ===== design/sfe_spi_engine.sv
// spi transfer format engine: registers, bit clock, shifter, flags
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/10ps
module sfe_spi_engine (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register port
    input wire sfe_pkg::sfe_bus_req_type bus_req,
    output logic [7:0] rd_data,
    // serial pins
    input wire sfe_pkg::sfe_pin_in_type pin_in,
    output sfe_pkg::sfe_pin_out_type pin_out
);
    import sfe_pkg::*;

    logic [7:0] ctrl;
    logic rx_full, ovr, role_conflict_flag, tx_empty, errie, modfen;
    logic [1:0] rate;
    logic [7:0] tx_buf, rx_data, shreg, rxsh, assembled, stat_val;
    logic arm_full, arm_ovr, arm_role_conflict_flag, xfer_lost, sck_act, bphase;
    sfe_state_type state;
    logic [4:0] edge_cnt, next_cnt;
    logic [6:0] div_cnt, half_lim;
    logic [3:0] pin_raw, s1, s2, s3, pin_f;
    logic sck_f, mosi_f, miso_f, ss_f, sck_q, ss_q;
    logic en, mstr, clock_idle_polarity, clock_sample_phase, master_on, tick, in_bit;
    logic wr_ctrl, wr_stat, wr_data, rd_stat, rd_dat;
    logic slave_edge, ss_fall, ss_rise, start_m, start_s0, start_s1;
    logic edge_ev, sample_ev, shift_ev, done_ev, first_smp, load_ev;
    logic m_fault, s_fault;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    assign pin_raw = pin_in;
    // a change is accepted once the second and third stages agree
    for (genvar i = 0; i < 4; i++) begin : g_sync
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                s1[i] <= SFE_PIN_IDLE[i];
                s2[i] <= SFE_PIN_IDLE[i];
                s3[i] <= SFE_PIN_IDLE[i];
                pin_f[i] <= SFE_PIN_IDLE[i];
            end else begin
                s1[i] <= pin_raw[i];
                s2[i] <= s1[i];
                s3[i] <= s2[i];
                if (s2[i] == s3[i]) begin
                    pin_f[i] <= s3[i];
                end
            end
        end
    end
    assign sck_f = pin_f[3];
    assign mosi_f = pin_f[2];
    assign miso_f = pin_f[1];
    assign ss_f = pin_f[0];

    // previous filtered levels for edge detection
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sck_q <= 1'b0;
            ss_q <= 1'b1;
        end else begin
            sck_q <= sck_f;
            ss_q <= ss_f;
        end
    end

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    assign en = ctrl[SFE_CTRL_EN];
    assign mstr = ctrl[SFE_CTRL_MSTR];
    assign clock_idle_polarity = ctrl[SFE_CTRL_CLOCK_IDLE_POLARITY];
    assign clock_sample_phase = ctrl[SFE_CTRL_CLOCK_SAMPLE_PHASE];
    assign master_on = en && mstr;
    assign wr_ctrl = bus_req.wr && bus_req.addr == SFE_ADDR_CTRL;
    assign wr_stat = bus_req.wr && bus_req.addr == SFE_ADDR_STAT;
    assign wr_data = bus_req.wr && bus_req.addr == SFE_ADDR_DATA;
    assign rd_stat = bus_req.rd && bus_req.addr == SFE_ADDR_STAT;
    assign rd_dat = bus_req.rd && bus_req.addr == SFE_ADDR_DATA;

    // ---------------------------------------------------------------
    // controller bit clock
    // ---------------------------------------------------------------
    // rate code to half bit period
    always_comb begin
        case (rate)
            SFE_RATE_DIVIDE_BY_TWO: half_lim = SFE_HALF_DIVIDE_BY_TWO;
            SFE_RATE_DIVIDE_BY_EIGHT: half_lim = SFE_HALF_DIVIDE_BY_EIGHT;
            SFE_RATE_DIVIDE_BY_THIRTYTWO: half_lim = SFE_HALF_DIVIDE_BY_THIRTYTWO;
            default: half_lim = SFE_HALF_DIVIDE_BY_ONETWENTYEIGHT;
        endcase
    end

    // free-running divider, stopped to save power unless enabled controller
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt <= '0;
            bphase <= 1'b0;
        end else if (!master_on) begin
            div_cnt <= '0;
            bphase <= 1'b0;
        end else if (div_cnt == half_lim - 7'h01) begin
            div_cnt <= '0;
            bphase <= ~bphase;
        end else begin
            div_cnt <= div_cnt + 7'h01;
        end
    end
    // edges fall on the bus clock grid; one tick per half bit
    assign tick = master_on && div_cnt == half_lim - 7'h01;

    // ---------------------------------------------------------------
    // transfer events
    // ---------------------------------------------------------------
    assign slave_edge = en && !mstr && !ss_f && sck_f != sck_q;
    assign ss_fall = ss_q && !ss_f;
    assign ss_rise = !ss_q && ss_f;
    // start only on a bit boundary, so the wait is under one bit time
    assign start_m = state == SFE_WAIT && tick && !bphase;
    assign start_s0 = en && !mstr && !clock_sample_phase && ss_fall && state == SFE_IDLE;
    // select may simply stay low between phase 1 bytes
    assign start_s1 = slave_edge && clock_sample_phase && state == SFE_IDLE;
    assign edge_ev = state == SFE_RUN && (mstr ? tick : slave_edge);
    assign next_cnt = edge_cnt + 5'h01;
    // phase 0 samples odd edges, phase 1 even edges
    assign sample_ev = edge_ev && (next_cnt[0] ^ clock_sample_phase);
    assign shift_ev = edge_ev && !(next_cnt[0] ^ clock_sample_phase) && next_cnt != SFE_EDGES;
    assign done_ev = edge_ev && next_cnt == SFE_EDGES;
    assign first_smp = sample_ev && next_cnt <= SFE_FIRST_SAMPLE_LIM;
    assign in_bit = mstr ? miso_f : mosi_f;
    assign assembled = sample_ev ? {rxsh[6:0], in_bit} : rxsh;
    assign load_ev = en && state == SFE_IDLE && !tx_empty && !start_s0 && !start_s1;
    // own select pulled low while controller
    assign m_fault = master_on && modfen && !ss_f;
    assign s_fault = en && !mstr && modfen && ss_rise && state == SFE_RUN;

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= SFE_IDLE;
        end else if (!en || m_fault) begin
            state <= SFE_IDLE;
        end else begin
            case (state)
                SFE_IDLE: begin
                    if (start_s0 || start_s1) begin
                        state <= SFE_RUN;
                    end else if (load_ev && mstr) begin
                        state <= SFE_WAIT;
                    end
                end
                SFE_WAIT: begin
                    if (start_m) begin
                        state <= SFE_RUN;
                    end
                end
                SFE_RUN: begin
                    // a deselected target ignores further clocks
                    if (done_ev || (!mstr && ss_f)) begin
                        state <= SFE_IDLE;
                    end
                end
                default: state <= SFE_IDLE;
            endcase
        end
    end

    // edge counter and controller clock level
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            edge_cnt <= '0;
            sck_act <= 1'b0;
        end else if (start_m) begin
            // phase 1 opens with the leading edge, phase 0 waits half a bit
            edge_cnt <= clock_sample_phase ? SFE_FIRST_EDGE : '0;
            sck_act <= clock_sample_phase;
        end else if (start_s1) begin
            edge_cnt <= SFE_FIRST_EDGE;
        end else if (start_s0) begin
            edge_cnt <= '0;
        end else if (edge_ev) begin
            edge_cnt <= next_cnt;
            sck_act <= mstr && !sck_act;
        end else if (state != SFE_RUN) begin
            sck_act <= 1'b0;
        end
    end

    // shift register: loads only while idle, so later writes stay buffered
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shreg <= '0;
        end else if (load_ev) begin
            shreg <= tx_buf;
        end else if (done_ev) begin
            shreg <= assembled;
        end else if (shift_ev) begin
            shreg <= {shreg[6:0], 1'b0};
        end
    end

    // receive shifter: one bit per capture strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rxsh <= '0;
        end else if (sample_ev) begin
            rxsh <= {rxsh[6:0], in_bit};
        end
    end

    // ---------------------------------------------------------------
    // registers and flags
    // ---------------------------------------------------------------
    // control register; a controller fault drops the enable bit
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= SFE_CTRL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl <= bus_req.wdata;
            end
            if (m_fault) begin
                ctrl[SFE_CTRL_EN] <= 1'b0;
            end
        end
    end

    // status control bits that software owns
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            errie <= 1'b0;
            modfen <= 1'b0;
            rate <= SFE_RATE_DIVIDE_BY_TWO;
        end else if (wr_stat) begin
            errie <= bus_req.wdata[SFE_STAT_ERRIE];
            modfen <= bus_req.wdata[SFE_STAT_MODFEN];
            rate <= bus_req.wdata[SFE_STAT_RATE_HI:SFE_STAT_RATE_LO];
        end
    end

    // transmit buffer; a fresh write beats a same-cycle move out
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_buf <= '0;
            tx_empty <= 1'b1;
        end else if (wr_data) begin
            tx_buf <= bus_req.wdata;
            tx_empty <= 1'b0;
        end else if (load_ev || m_fault) begin
            tx_empty <= 1'b1;
        end
    end

    // overrun marks the running transfer as lost at its first capture
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            xfer_lost <= 1'b0;
        end else if (start_m || start_s0 || start_s1) begin
            xfer_lost <= 1'b0;
        end else if (first_smp && rx_full) begin
            xfer_lost <= 1'b1;
        end
    end

    // receive full and data: status read arms, data read clears, set wins
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_full <= 1'b0;
            rx_data <= '0;
            arm_full <= 1'b0;
        end else begin
            if (rd_stat) begin
                arm_full <= rx_full;
            end else if (rd_dat) begin
                arm_full <= 1'b0;
            end
            if (done_ev && !xfer_lost) begin
                rx_full <= 1'b1;
                rx_data <= assembled;
            end else if (rd_dat && arm_full) begin
                rx_full <= 1'b0;
            end
        end
    end

    // overrun flag: status read then data read clears it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ovr <= 1'b0;
            arm_ovr <= 1'b0;
        end else begin
            if (rd_stat) begin
                arm_ovr <= ovr;
            end else if (rd_dat) begin
                arm_ovr <= 1'b0;
            end
            if (first_smp && rx_full) begin
                ovr <= 1'b1;
            end else if (rd_dat && arm_ovr) begin
                ovr <= 1'b0;
            end
        end
    end

    // role conflict: status read then control write clears, only while quiet
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            role_conflict_flag <= 1'b0;
            arm_role_conflict_flag <= 1'b0;
        end else begin
            if (rd_stat) begin
                arm_role_conflict_flag <= role_conflict_flag;
            end else if (wr_ctrl) begin
                arm_role_conflict_flag <= 1'b0;
            end
            if (m_fault || s_fault) begin
                role_conflict_flag <= 1'b1;
            end else if (wr_ctrl && arm_role_conflict_flag) begin
                role_conflict_flag <= 1'b0;
            end
        end
    end

    // status image
    always_comb begin
        stat_val = '0;
        stat_val[SFE_STAT_FULL] = rx_full;
        stat_val[SFE_STAT_ERRIE] = errie;
        stat_val[SFE_STAT_OVR] = ovr;
        stat_val[SFE_STAT_ROLE_CONFLICT_FLAG] = role_conflict_flag;
        stat_val[SFE_STAT_TXE] = tx_empty;
        stat_val[SFE_STAT_MODFEN] = modfen;
        stat_val[SFE_STAT_RATE_HI:SFE_STAT_RATE_LO] = rate;
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= '0;
        end else if (!bus_req.rd) begin
            rd_data <= '0;
        end else begin
            case (bus_req.addr)
                SFE_ADDR_CTRL: rd_data <= ctrl;
                SFE_ADDR_STAT: rd_data <= stat_val;
                SFE_ADDR_DATA: rd_data <= rx_data;
                default: rd_data <= '0;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // pins
    // ---------------------------------------------------------------
    assign pin_out.sck_out = clock_idle_polarity ^ sck_act;
    assign pin_out.sck_oe = master_on;
    assign pin_out.mosi_out = shreg[7];
    assign pin_out.mosi_oe = master_on;
    assign pin_out.miso_out = shreg[7];
    // a deselected target keeps off the shared line
    assign pin_out.miso_oe = en && !mstr && !ss_f;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    logic [7:0] wait_cnt;
    logic [3:0] smp_cnt;
    // helper counters: cycles spent waiting, samples taken this transfer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_cnt <= '0;
            smp_cnt <= '0;
        end else begin
            wait_cnt <= state == SFE_WAIT ? wait_cnt + 8'h01 : '0;
            if (start_m || start_s0 || start_s1) begin
                smp_cnt <= '0;
            end else if (sample_ev) begin
                smp_cnt <= smp_cnt + 4'h1;
            end
        end
    end

    sequence s_ctrl_start;
        start_m;
    endsequence
    sequence s_lost_end;
        done_ev && xfer_lost;
    endsequence

    idle_miso_off_a: assert property (ss_f |-> !pin_out.miso_oe)
        else $error("miso driven while deselected");
    start_level_a: assert property (s_ctrl_start |=> sck_act == $past(clock_sample_phase))
        else $error("wrong sck level after controller start");
    start_delay_a: assert property (state == SFE_WAIT |-> wait_cnt < {half_lim, 1'b0})
        else $error("controller start later than one bit time");
    clock_gate_a: assert property (!master_on |=> div_cnt == '0 && !bphase)
        else $error("bit clock runs while not enabled controller");
    eight_bits_a: assert property (done_ev |-> smp_cnt + {3'h0, sample_ev} == SFE_BITS)
        else $error("transfer did not carry eight bits");
    rx_store_a: assert property (done_ev && !xfer_lost |=> rx_full && rx_data == $past(assembled))
        else $error("received byte not stored");
    // software may already have cleared the flag, so only the stored byte is held here
    overrun_keep_a: assert property (s_lost_end |=> $stable(rx_data))
        else $error("overrun byte overwrote unread data");
    overrun_set_a: assert property (first_smp && rx_full |=> ovr)
        else $error("overrun not flagged at first capture");
    buffer_hold_a: assert property (state == SFE_RUN && wr_data && !shift_ev && !done_ev
        |=> $stable(shreg) && !tx_empty)
        else $error("shift register loaded mid transfer");
    target_start_a: assert property (start_s0 |=> state == SFE_RUN && edge_cnt == '0)
        else $error("phase 0 target did not start on select fall");
    ctrl_fault_a: assert property (m_fault |=> role_conflict_flag && !en ##1 tx_empty)
        else $error("controller fault not handled");
endmodule

// ===== tb/sfe_peer.sv
// partner model: external spi target and controller facing the engine
`timescale 1ns/10ps
module sfe_peer (
    // clock, format, wire levels and drives
    input wire logic clk,
    input wire logic clock_idle_polarity,
    input wire logic clock_sample_phase,
    input wire logic sck_w,
    input wire logic mosi_w,
    input wire logic miso_w,
    output logic sck_drv = 1'b0,
    output logic mosi_drv = 1'b0,
    output logic miso_drv = 1'b0,
    output logic ss_n = 1'b1
);
    logic [7:0] t_tx = 8'h00;
    logic [7:0] t_rx = 8'h00;
    logic t_sel = 1'b0;
    logic mosi_pre = 1'b0;
    // line level just before each bus clock edge; the engine may move mosi on that edge
    always @(posedge clk) mosi_pre = mosi_w;
    // clock idles at the polarity level; only changed while the engine is off
    always @(clock_idle_polarity) sck_drv <= clock_idle_polarity;
    // target: shift on one edge kind, capture on the other
    always @(sck_w) begin
        if (t_sel && ((sck_w != clock_idle_polarity) == clock_sample_phase)) begin
            miso_drv = t_tx[7];
            t_tx = {t_tx[6:0], 1'b0};
        end else if (t_sel) begin
            t_rx = {t_rx[6:0], mosi_pre};
        end
    end
    // target select; phase 0 puts the msb out at once
    task automatic tsel(input logic [7:0] d);
        t_tx = d;
        t_sel = 1'b1;
        if (!clock_sample_phase) begin
            miso_drv = d[7];
            t_tx = {d[6:0], 1'b0};
        end
    endtask
    // a released line shows the inverse of its last bit, never a held value
    task automatic tdesel;
        t_sel = 1'b0;
        miso_drv = ~miso_drv;
    endtask
    // controller frame, slow enough for the pin synchroniser; select rises per byte
    task automatic ctl(input logic [7:0] d, output logic [7:0] r);
        r = 8'h00;
        ss_n <= 1'b0;
        mosi_drv <= d[7];
        for (int i = 7; i >= 0; i--) begin
            repeat (8) @(posedge clk);
            if (!clock_sample_phase) r = {r[6:0], miso_w};
            sck_drv <= ~clock_idle_polarity;
            if (clock_sample_phase) mosi_drv <= d[i];
            repeat (8) @(posedge clk);
            if (clock_sample_phase) r = {r[6:0], miso_w};
            sck_drv <= clock_idle_polarity;
            if (!clock_sample_phase && i > 0) mosi_drv <= d[i-1];
        end
        repeat (8) @(posedge clk);
        ss_n <= 1'b1;
        mosi_drv <= ~mosi_drv;
    endtask
endmodule

// ===== tb/tb.sv
// self-checking bench for the spi transfer format engine
`timescale 1ns/10ps
module tb;
    import sfe_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    sfe_bus_req_type req = '0;
    logic [7:0] rd_data, s, r;
    sfe_pin_out_type po;
    logic clock_idle_polarity = 1'b0, clock_sample_phase = 1'b0, ss_bad = 1'b0;
    logic p_sck, p_mosi, p_miso, p_ss, sck_w, mosi_w, miso_w;
    int n_mismatch = 0, comparisons = 0, n;
    // wire levels resolved from the engine's enables; the peer drives otherwise
    assign sck_w = po.sck_oe ? po.sck_out : p_sck;
    assign mosi_w = po.mosi_oe ? po.mosi_out : p_mosi;
    assign miso_w = po.miso_oe ? po.miso_out : p_miso;
    sfe_spi_engine i_dut (.clk(clk), .arst_n(arst_n), .bus_req(req), .rd_data(rd_data),
        .pin_in({sck_w, mosi_w, miso_w, p_ss & ~ss_bad}), .pin_out(po));
    sfe_peer i_peer (.clk(clk), .clock_idle_polarity(clock_idle_polarity), .clock_sample_phase(clock_sample_phase), .sck_w(sck_w), .mosi_w(mosi_w),
        .miso_w(miso_w), .sck_drv(p_sck), .mosi_drv(p_mosi), .miso_drv(p_miso), .ss_n(p_ss));
    // 100 mhz bus clock
    initial begin
        forever #5 clk = ~clk;
    end
    // watchdog: the full run needs well under 20k cycles
    initial begin
        #400000;
        n_mismatch++;
        stop_test();
    end
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] got, want);
        comparisons++;
        if (got !== want) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, want, got);
        end
    endtask
    // bus cycles: one strobe cycle, one quiet cycle; read data taken at the edge closing it
    task automatic wr(input logic [7:0] a, d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
        s = rd_data;
    endtask
    task automatic poll(input logic [7:0] a, input int b, input logic v);
        int k = 0;
        do begin
            rd(a);
            k++;
        end while (s[b] !== v && k < 3000);
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd(SFE_ADDR_CTRL);
        chk("ctrl_rst", s, SFE_CTRL_RESET);
        rd(SFE_ADDR_STAT);
        chk("stat_rst", s, 8'h08);
        rd(8'h13);
        chk("unmapped", s, 8'h00);
        // controller: every format and every rate, one byte each way; the returned byte is checked only at the two slow rates
        for (int m = 0; m < 4; m++) begin
            // slow rates first: the three-stage input filter lags a fast controller capture
            wr(SFE_ADDR_STAT, 8'((m + 2) % 4));
            wr(SFE_ADDR_CTRL, 8'h20 | 8'(m << 3));
            {clock_idle_polarity, clock_sample_phase} = 2'(m);
            wr(SFE_ADDR_CTRL, 8'h22 | 8'(m << 3));
            i_peer.tsel(8'ha5 ^ 8'(m));
            wr(SFE_ADDR_DATA, 8'h3c + 8'(m));
            #1 n = 0;
            while (sck_w === clock_idle_polarity && n < 300) begin
                #10 n++;
            end
            chk("start_dly", 8'(n <= 6 + 3 * (1 << 2 * ((m + 2) % 4))), 8'h01);
            poll(SFE_ADDR_STAT, SFE_STAT_FULL, 1'b1);
            chk("peer_rx", i_peer.t_rx, 8'h3c + 8'(m));
            rd(SFE_ADDR_DATA);
            if (m < 2) chk("ctl_rx", s, 8'ha5 ^ 8'(m));
            rd(SFE_ADDR_STAT);
            chk("full_clr", s & 8'h80, 8'h00);
            i_peer.tdesel();
        end
        // overrun: a second byte lands on the unread first one
        wr(SFE_ADDR_STAT, 8'h02);
        i_peer.tsel(8'h81);
        wr(SFE_ADDR_DATA, 8'h11);
        poll(SFE_ADDR_STAT, SFE_STAT_FULL, 1'b1);
        i_peer.tsel(8'h42);
        wr(SFE_ADDR_DATA, 8'h22);
        poll(SFE_ADDR_STAT, SFE_STAT_OVR, 1'b1);
        chk("ovr_set", s & 8'ha0, 8'ha0);
        rd(SFE_ADDR_DATA);
        chk("ovr_keep", s, 8'h81);
        // let the lost transfer finish; its byte must not reach the receive register
        repeat (300) @(posedge clk);
        rd(SFE_ADDR_DATA);
        chk("ovr_drop", s, 8'h81);
        i_peer.tdesel();
        // role conflict: own select pulled low while controller, between frames
        wr(SFE_ADDR_STAT, 8'h04);
        ss_bad <= 1'b1;
        poll(SFE_ADDR_CTRL, SFE_CTRL_EN, 1'b0);
        chk("conflict_en", s, 8'h38);
        rd(SFE_ADDR_STAT);
        chk("conflict_flag", s & 8'h18, 8'h18);
        ss_bad <= 1'b0;
        wr(SFE_ADDR_CTRL, 8'h00);
        // target: both phases; a write mid-frame waits for the next byte
        for (int m = 0; m < 2; m++) begin
            wr(SFE_ADDR_CTRL, 8'(m << 3));
            {clock_idle_polarity, clock_sample_phase} = 2'(m);
            wr(SFE_ADDR_CTRL, 8'h02 | 8'(m << 3));
            wr(SFE_ADDR_DATA, 8'h96);
            chk("oe_idle", {7'h00, po.miso_oe}, 8'h00);
            fork
                i_peer.ctl(8'h5a, r);
                begin
                    repeat (40) @(posedge clk);
                    chk("oe_sel", {7'h00, po.miso_oe}, 8'h01);
                    wr(SFE_ADDR_DATA, 8'h71);
                end
            join
            chk("miso_1", r, 8'h96);
            rd(SFE_ADDR_STAT);
            rd(SFE_ADDR_DATA);
            chk("mosi_1", s, 8'h5a);
            i_peer.ctl(8'hc3, r);
            chk("miso_2", r, 8'h71);
            rd(SFE_ADDR_STAT);
            rd(SFE_ADDR_DATA);
            chk("mosi_2", s, 8'hc3);
        end
        stop_test();
    end
endmodule
